//--- dod_assertions.sv
`timescale 1ns/1ps
module dod_assertions
  import dod_pkg::*;
(
  input wire logic        clock_i,        // System clock
  input wire logic        sys_rst_i,      // Async reset
  input wire logic        req,            // Link request
  input wire logic        wr,             // Write flag
  input wire logic [15:0] index,          // Object index
  input wire logic [7:0]  subidx,         // Subindex
  input wire logic        ack,            // Answer pulse
  input wire logic        err,            // Refusal flag
  input wire logic [31:0] rdata,          // Read value
  input wire logic        profile_active  // Profile flag
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic take;
  logic is_rd;
  assign take = req && !ack;
  assign is_rd = take && !wr;

  a_answer_next: assert property (take |=> ack)
    else $error("request not answered next cycle");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  a_err_with_ack: assert property (err |-> ack)
    else $error("err without ack");
  a_cmd_read_refused: assert property (is_rd && index == DOD_IDX_CMD |=> err)
    else $error("command object read not refused");
  a_cmd_write_ok: assert property (take && wr && index == DOD_IDX_CMD && subidx == 8'h00
    |=> ack && !err)
    else $error("command write refused");
  a_mod_count: assert property (is_rd && index == DOD_IDX_MOD && subidx == 8'h00
    |=> !err && rdata == 32'h0000003f)
    else $error("module subindex count wrong");
  a_mot_count: assert property (is_rd && (index == DOD_IDX_MOT || index == DOD_IDX_XMOT)
    && subidx == 8'h00 |=> !err && rdata == 32'h000000fe)
    else $error("motor subindex count wrong");
  a_mod_ro_refused: assert property (take && wr && index == DOD_IDX_MOD
    && (subidx < DOD_MOD_RW_LO || subidx > DOD_MOD_RW_HI) |=> err)
    else $error("read-only module write accepted");
  a_mod_rw_ok: assert property (take && wr && index == DOD_IDX_MOD
    && subidx >= DOD_MOD_RW_LO && subidx <= DOD_MOD_RW_HI |=> ack && !err)
    else $error("writable module register refused");
  a_profile_fixed: assert property (ack |-> $stable(profile_active))
    else $error("profile flag changed in run");
endmodule

//--- dod_device.sv
// Notes on behaviour
// - Write-only 32-bit command object at 2010
// - Command write acts like module register 15
// - Object 2011 subindex equals module register
// - Module object reports subindex count 63
// - Subindices 3 to 31 writable, others refused
// - Object 2012 reaches motor register n
// - Object 2013 reaches motor register subindex+255
// - Object 2013 exists on larger family only
// - Changes volatile until save command is issued
// - Mode codes 1,3,6,8,9,10; torque large only
// - Master runs distributed clock for cyclic modes
// - Small variants: no clock sync, 16ms minimum
// - Set passive start, no zero search first
// - Absolute moves need resync after passive
// - Master avoids motor writes under profile
// - Profile default on; change at next power-up
// - All mandatory profile functions are present
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module dod_device #(
  parameter bit          LARGE_FAMILY  = 1'b1,
  parameter int          MOT_DEPTH     = 510,
  parameter int          MIN_CYCLE_CYC = dod_pkg::DOD_MIN_CYCLE_CYC,
  parameter logic [31:0] SAVE_CMD      = dod_pkg::DOD_SAVE_CMD_DEF
) (
  input  wire logic  clock_i,          // System clock
  input  wire logic  sys_rst_i,        // Async reset, active high
  dod_if.device      bus,              // Object access from master
  input  wire logic  nv_profile_en_i,  // Saved profile enable
  output logic       save_o,           // Pulse: store to flash
  output logic       save_profile_o,   // Profile enable to store
  output logic [7:0] op_mode_o,        // Active operating mode
  output logic       mode_ok_o,        // Mode code is supported
  output logic       dc_supported_o,   // Clock sync available
  output logic       cycle_tick_o,     // Pulse: cyclic frame slot
  output logic       motor_wr_o,       // Pulse: motor reg written
  output logic [8:0] motor_addr_o      // Motor reg written
);
  import dod_pkg::*;

  logic [31:0] mod_reg [0:63];
  logic [31:0] mot_reg [0:MOT_DEPTH-1];
  logic        acc_err;
  logic        is_cmd;
  logic        is_mod;
  logic        is_mot;
  logic        is_count;
  logic [7:0]  count_val;
  logic [8:0]  mot_idx;
  logic        do_wr;
  logic        save_hit;
  logic        boot_done;
  logic        profile_active;
  logic [31:0] cyc_cnt;
  logic [31:0] eff_period;
  logic [7:0]  mode_val;
  logic        cyclic_mode;

  // Access decode: one cycle, every illegal case flagged
  always_comb begin
    acc_err   = 1'b0;
    is_cmd    = 1'b0;
    is_mod    = 1'b0;
    is_mot    = 1'b0;
    is_count  = 1'b0;
    count_val = 8'h00;
    mot_idx   = {1'b0, bus.subidx};
    if (bus.index == DOD_IDX_CMD) begin
      is_cmd  = 1'b1;
      acc_err = !bus.wr || (bus.subidx != 8'h00);
    end else if (bus.index == DOD_IDX_MOD) begin
      if (bus.subidx == 8'h00) begin
        is_count  = 1'b1;
        count_val = DOD_MOD_COUNT;
        acc_err   = bus.wr;
      end else if (bus.subidx > DOD_MOD_COUNT) begin
        acc_err = 1'b1;
      end else begin
        is_mod  = 1'b1;
        acc_err = bus.wr && ((bus.subidx < DOD_MOD_RW_LO) ||
                             (bus.subidx > DOD_MOD_RW_HI));
      end
    end else if (bus.index == DOD_IDX_MOT) begin
      if (bus.subidx == 8'h00) begin
        is_count  = 1'b1;
        count_val = DOD_MOT_COUNT;
        acc_err   = bus.wr;
      end else if (bus.subidx > DOD_MOT_COUNT) begin
        acc_err = 1'b1;
      end else begin
        is_mot = 1'b1;
      end
    end else if ((bus.index == DOD_IDX_XMOT) && LARGE_FAMILY) begin
      mot_idx = 9'({1'b0, bus.subidx} + DOD_XMOT_BASE);
      if (bus.subidx == 8'h00) begin
        is_count  = 1'b1;
        count_val = DOD_MOT_COUNT;
        acc_err   = bus.wr;
      end else if (bus.subidx > DOD_MOT_COUNT) begin
        acc_err = 1'b1;
      end else begin
        is_mot = 1'b1;
      end
    end else begin
      acc_err = 1'b1;
    end
    if (is_mot && (int'(mot_idx) >= MOT_DEPTH)) begin
      is_mot  = 1'b0;
      acc_err = 1'b1;
    end
  end

  assign do_wr = bus.req && !bus.ack && bus.wr && !acc_err;

  // Register 15 through 2011 is the same command path as object 2010
  assign save_hit = do_wr && (bus.wdata == SAVE_CMD) &&
                    (is_cmd || (is_mod && (bus.subidx[5:0] == DOD_CMD_REG)));

  // Answer one cycle after the request is seen
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus.ack   <= 1'b0;
      bus.err   <= 1'b0;
      bus.rdata <= 32'h00000000;
    end else if (bus.req && !bus.ack) begin
      bus.ack <= 1'b1;
      bus.err <= acc_err;
      if (acc_err || bus.wr) begin
        bus.rdata <= 32'h00000000;
      end else if (is_count) begin
        bus.rdata <= {24'h000000, count_val};
      end else if (is_mod && (bus.subidx[5:0] == DOD_STATE_REG)) begin
        bus.rdata <= {29'h0, profile_active, mode_ok_o, dc_supported_o};
      end else if (is_mod) begin
        bus.rdata <= mod_reg[bus.subidx[5:0]];
      end else begin
        bus.rdata <= mot_reg[mot_idx];
      end
    end else begin
      bus.ack <= 1'b0;
      bus.err <= 1'b0;
    end
  end

  // Module registers: volatile working copy only
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 64; i++) begin
        mod_reg[i] <= DOD_REG_RST;
      end
    end else if (do_wr && is_cmd) begin
      mod_reg[DOD_CMD_REG] <= bus.wdata;
    end else if (do_wr && is_mod) begin
      mod_reg[bus.subidx[5:0]] <= bus.wdata;
    end
  end

  // Motor register store; large, so no reset
  always_ff @(posedge clock_i) begin
    if (do_wr && is_mot) begin
      mot_reg[mot_idx] <= bus.wdata;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      motor_wr_o   <= 1'b0;
      motor_addr_o <= 9'h000;
    end else begin
      motor_wr_o <= do_wr && is_mot;
      if (do_wr && is_mot) begin
        motor_addr_o <= mot_idx;
      end
    end
  end

  // Flash is touched only by the explicit save command
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      save_o         <= 1'b0;
      save_profile_o <= 1'b1;
    end else begin
      save_o <= save_hit;
      if (save_hit) begin
        save_profile_o <= mod_reg[DOD_PROF_REG][0];
      end
    end
  end

  // Profile choice is taken once after reset release, so a saved
  // change never takes effect while running
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      boot_done      <= 1'b0;
      profile_active <= 1'b1;
    end else if (!boot_done) begin
      boot_done      <= 1'b1;
      profile_active <= nv_profile_en_i;
    end
  end

  assign bus.profile_active = profile_active;

  // Operating mode decode
  assign mode_val = mod_reg[DOD_MODE_REG][7:0];
  assign cyclic_mode = (mode_val == DOD_MODE_CSP) || (mode_val == DOD_MODE_CSV) ||
                       (mode_val == DOD_MODE_CST);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_mode_o      <= 8'h00;
      mode_ok_o      <= 1'b0;
      dc_supported_o <= 1'b0;
    end else begin
      op_mode_o      <= mode_val;
      dc_supported_o <= LARGE_FAMILY;
      mode_ok_o      <= (mode_val == DOD_MODE_PP) || (mode_val == DOD_MODE_PV) ||
                        (mode_val == DOD_MODE_HM) || (mode_val == DOD_MODE_CSP) ||
                        (mode_val == DOD_MODE_CSV) ||
                        ((mode_val == DOD_MODE_CST) && LARGE_FAMILY);
    end
  end

  // Cyclic slot timer; small variants are clamped to the minimum
  always_comb begin
    eff_period = mod_reg[DOD_CYC_REG];
    if (!LARGE_FAMILY && (eff_period < 32'(MIN_CYCLE_CYC))) begin
      eff_period = 32'(MIN_CYCLE_CYC);
    end
    if (eff_period == 32'h00000000) begin
      eff_period = 32'h00000001;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cyc_cnt      <= 32'h00000000;
      cycle_tick_o <= 1'b0;
    end else if (profile_active && cyclic_mode && mode_ok_o) begin
      if (cyc_cnt >= eff_period - 32'h00000001) begin
        cyc_cnt      <= 32'h00000000;
        cycle_tick_o <= 1'b1;
      end else begin
        cyc_cnt      <= cyc_cnt + 32'h00000001;
        cycle_tick_o <= 1'b0;
      end
    end else begin
      cyc_cnt      <= 32'h00000000;
      cycle_tick_o <= 1'b0;
    end
  end
endmodule

//--- dod_if.sv
`timescale 1ns/1ps
interface dod_if;
  logic        req;
  logic        wr;
  logic [15:0] index;
  logic [7:0]  subidx;
  logic [31:0] wdata;
  logic        ack;
  logic        err;
  logic [31:0] rdata;
  logic        profile_active;

  modport device (
    input  req, wr, index, subidx, wdata,
    output ack, err, rdata, profile_active
  );
  modport master (
    output req, wr, index, subidx, wdata,
    input  ack, err, rdata, profile_active
  );
endinterface

//--- dod_master.sv
`timescale 1ns/1ps
module dod_master (
  input  wire logic        clock_i,    // System clock
  input  wire logic        sys_rst_i,  // Async reset, active high
  dod_if.master            bus,        // Object access to device
  input  wire logic        hsel,       // AHB select
  input  wire logic [31:0] haddr,      // AHB address
  input  wire logic [1:0]  htrans,     // AHB transfer type
  input  wire logic        hwrite,     // AHB write
  input  wire logic [2:0]  hsize,      // AHB size (word only)
  input  wire logic [31:0] hwdata,     // AHB write data
  input  wire logic        hready,     // AHB bus ready
  output logic      [31:0] hrdata,     // AHB read data
  output logic             hreadyout,  // AHB slave ready
  output logic             hresp       // AHB response, OKAY
);
  import dod_pkg::*;

  dod_hstate_t state;
  logic        ap_wr;
  logic [7:0]  ap_addr;
  logic        wr_ctrl;
  logic        wr_req;
  logic        wr_wdata;
  logic        wr_stat;
  logic [4:0]  ctrl;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic        done;
  logic        err;
  logic        refused;
  logic        refuse_now;
  logic        finish;
  logic [15:0] req_index;
  logic [7:0]  req_sub;
  logic        req_wr;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ap_wr   <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready) begin
      ap_wr   <= hsel && htrans[1] && hwrite;
      ap_addr <= haddr[7:0];
    end
  end

  assign wr_ctrl  = ap_wr && (ap_addr == DOD_H_CTRL);
  assign wr_req   = ap_wr && (ap_addr == DOD_H_REQ);
  assign wr_wdata = ap_wr && (ap_addr == DOD_H_WDATA);
  assign wr_stat  = ap_wr && (ap_addr == DOD_H_STAT);

  // Read data is latched in the address phase: zero wait states
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:0] == DOD_H_CTRL) begin
        hrdata <= {27'h0, ctrl};
      end else if (haddr[7:0] == DOD_H_WDATA) begin
        hrdata <= wdata_r;
      end else if (haddr[7:0] == DOD_H_RDATA) begin
        hrdata <= rdata_r;
      end else if (haddr[7:0] == DOD_H_STAT) begin
        hrdata <= {27'h0, bus.profile_active, refused, err, done,
                   state == DOD_HS_WAIT};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl    <= DOD_CTRL_RST;
      wdata_r <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        ctrl <= hwdata[4:0];
      end
      if (wr_wdata) begin
        wdata_r <= hwdata;
      end
    end
  end

  // Screen orders that would break drive-profile operation
  always_comb begin
    req_index  = hwdata[15:0];
    req_sub    = hwdata[23:16];
    req_wr     = hwdata[DOD_REQ_WR];
    refuse_now = 1'b0;
    if (req_wr && bus.profile_active &&
        ((req_index == DOD_IDX_MOT) || (req_index == DOD_IDX_XMOT))) begin
      refuse_now = 1'b1;
    end
    if (req_wr && (req_index == DOD_IDX_MOD) && (req_sub == {2'b00, DOD_MODE_REG}) &&
        ((wdata_r[7:0] == DOD_MODE_CSP) || (wdata_r[7:0] == DOD_MODE_CSV) ||
         (wdata_r[7:0] == DOD_MODE_CST)) && !ctrl[DOD_C_DC]) begin
      refuse_now = 1'b1;
    end
    if (req_wr && (req_index == DOD_IDX_MOD) && (req_sub == {2'b00, DOD_PROF_REG}) &&
        wdata_r[0]) begin
      if (!ctrl[DOD_C_PASSIVE] || !ctrl[DOD_C_NOZERO]) begin
        refuse_now = 1'b1;
      end
      if (ctrl[DOD_C_ABS] && !ctrl[DOD_C_RESYNC]) begin
        refuse_now = 1'b1;
      end
    end
  end

  assign finish = (state == DOD_HS_WAIT) && bus.ack;

  // Request held until the device answers
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state      <= DOD_HS_IDLE;
      bus.req    <= 1'b0;
      bus.wr     <= 1'b0;
      bus.index  <= 16'h0000;
      bus.subidx <= 8'h00;
      bus.wdata  <= 32'h00000000;
      rdata_r    <= 32'h00000000;
    end else begin
      case (state)
        DOD_HS_IDLE: begin
          if (wr_req && !refuse_now) begin
            state      <= DOD_HS_WAIT;
            bus.req    <= 1'b1;
            bus.wr     <= req_wr;
            bus.index  <= req_index;
            bus.subidx <= req_sub;
            bus.wdata  <= wdata_r;
          end
        end
        DOD_HS_WAIT: begin
          if (bus.ack) begin
            state   <= DOD_HS_IDLE;
            bus.req <= 1'b0;
            rdata_r <= bus.rdata;
          end
        end
        default: begin
          state   <= DOD_HS_IDLE;
          bus.req <= 1'b0;
        end
      endcase
    end
  end

  // Sticky status, write 1 to clear; a new event wins over the clear
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done    <= 1'b0;
      err     <= 1'b0;
      refused <= 1'b0;
    end else begin
      done    <= finish || (done && !(wr_stat && hwdata[DOD_S_DONE]));
      err     <= (finish && bus.err) || (err && !(wr_stat && hwdata[DOD_S_ERR]));
      refused <= (wr_req && (state == DOD_HS_IDLE) && refuse_now) ||
                 (refused && !(wr_stat && hwdata[DOD_S_REFUSED]));
    end
  end
endmodule

//--- dod_pkg.sv
package dod_pkg;
  // Object indices seen by the fieldbus master
  localparam logic [15:0] DOD_IDX_CMD  = 16'h2010;
  localparam logic [15:0] DOD_IDX_MOD  = 16'h2011;
  localparam logic [15:0] DOD_IDX_MOT  = 16'h2012;
  localparam logic [15:0] DOD_IDX_XMOT = 16'h2013;
  // Subindex counts and module register layout
  localparam logic [7:0]  DOD_MOD_COUNT = 8'h3f;
  localparam logic [7:0]  DOD_MOT_COUNT = 8'hfe;
  localparam logic [7:0]  DOD_MOD_RW_LO = 8'h03;
  localparam logic [7:0]  DOD_MOD_RW_HI = 8'h1f;
  localparam logic [5:0]  DOD_CMD_REG   = 6'h0f;
  localparam logic [5:0]  DOD_PROF_REG  = 6'h14;
  localparam logic [5:0]  DOD_MODE_REG  = 6'h15;
  localparam logic [5:0]  DOD_CYC_REG   = 6'h16;
  localparam logic [5:0]  DOD_STATE_REG = 6'h20;
  localparam logic [8:0]  DOD_XMOT_BASE = 9'h0ff;
  localparam logic [31:0] DOD_REG_RST   = 32'h00000000;
  // Operating mode codes
  localparam logic [7:0] DOD_MODE_PP  = 8'h01;
  localparam logic [7:0] DOD_MODE_PV  = 8'h03;
  localparam logic [7:0] DOD_MODE_HM  = 8'h06;
  localparam logic [7:0] DOD_MODE_CSP = 8'h08;
  localparam logic [7:0] DOD_MODE_CSV = 8'h09;
  localparam logic [7:0] DOD_MODE_CST = 8'h0a;
  // Timing
  localparam int DOD_CLK_HZ       = 20000000;
  localparam int DOD_MIN_CYCLE_MS = 16;
  localparam int DOD_MIN_CYCLE_CYC = DOD_MIN_CYCLE_MS * (DOD_CLK_HZ / 1000);
  // Controller register map (byte addresses)
  localparam logic [7:0] DOD_H_CTRL  = 8'h00;
  localparam logic [7:0] DOD_H_REQ   = 8'h04;
  localparam logic [7:0] DOD_H_WDATA = 8'h08;
  localparam logic [7:0] DOD_H_RDATA = 8'h0c;
  localparam logic [7:0] DOD_H_STAT  = 8'h10;
  // Controller control bits
  localparam int DOD_C_DC      = 0;
  localparam int DOD_C_PASSIVE = 1;
  localparam int DOD_C_NOZERO  = 2;
  localparam int DOD_C_RESYNC  = 3;
  localparam int DOD_C_ABS     = 4;
  // Controller status bits
  localparam int DOD_S_BUSY    = 0;
  localparam int DOD_S_DONE    = 1;
  localparam int DOD_S_ERR     = 2;
  localparam int DOD_S_REFUSED = 3;
  localparam int DOD_S_PROFILE = 4;
  localparam int DOD_REQ_WR    = 24;
  localparam logic [4:0] DOD_CTRL_RST = 5'h00;
  localparam logic [31:0] DOD_SAVE_CMD_DEF = 32'h00000002;

  typedef enum logic [1:0] {
    DOD_HS_IDLE = 2'b01,
    DOD_HS_WAIT = 2'b10
  } dod_hstate_t;
endpackage

//--- tb_drive_object_dictionary_access.sv
`timescale 1ns/1ps
module tb_drive_object_dictionary_access;
  import dod_pkg::*;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        nv_en = 1'b0;
  logic        save, sv_prof, mode_ok, dc_sup, mot_wr, tick, hresp;
  logic [7:0]  op_mode;
  logic [8:0]  mot_addr, last_mot;
  logic [31:0] rd, v, st, dmy;
  logic [7:0]  s;
  logic [7:0]  modes [7];
  int          mismatches = 0;
  int          compares = 0;
  int          saves = 0;
  int          mots = 0;
  int          ticks = 0;

  dod_if bus_if();
  always #25 clock_i = ~clock_i;

  dod_device #(.MIN_CYCLE_CYC(20)) dod_device_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus(bus_if.device),
    .nv_profile_en_i(nv_en), .save_o(save), .save_profile_o(sv_prof),
    .op_mode_o(op_mode), .mode_ok_o(mode_ok), .dc_supported_o(dc_sup),
    .cycle_tick_o(tick), .motor_wr_o(mot_wr), .motor_addr_o(mot_addr));
  dod_master dod_master_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus(bus_if.master), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  dod_assertions dod_assertions_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .req(bus_if.req), .wr(bus_if.wr),
    .index(bus_if.index), .subidx(bus_if.subidx), .ack(bus_if.ack), .err(bus_if.err),
    .rdata(bus_if.rdata), .profile_active(bus_if.profile_active));

  // Pulses are counted here so the slow register polling cannot miss them
  always @(posedge clock_i) begin
    if (save === 1'b1) saves <= saves + 1;
    if (tick === 1'b1) ticks <= ticks + 1;
    if (mot_wr === 1'b1) begin
      mots <= mots + 1;
      last_mot <= mot_addr;
    end
  end

  task automatic final_report;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clock_i);
    while (hreadyout !== 1'b1) @(posedge clock_i);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock_i);
    while (hreadyout !== 1'b1) @(posedge clock_i);
    r = hrdata;
  endtask

  // One object access through the controller; leaves status in st, read data in rd
  task automatic obj(input logic [15:0] ix, input logic [7:0] sb, input logic w,
                     input logic [31:0] d, input logic e);
    ahb(DOD_H_WDATA, 1'b1, d, dmy);
    ahb(DOD_H_REQ, 1'b1, {7'h00, w, sb, ix}, dmy);
    for (int i = 0; i < 40; i++) begin
      ahb(DOD_H_STAT, 1'b0, 32'h0, st);
      if (st[DOD_S_DONE] === 1'b1 || st[DOD_S_REFUSED] === 1'b1) break;
    end
    ahb(DOD_H_STAT, 1'b1, 32'h0000000e, dmy);
    ahb(DOD_H_RDATA, 1'b0, 32'h0, rd);
    chk({31'h0, st[DOD_S_ERR]}, {31'h0, e});
  endtask

  initial begin
    #(6000 * 50);
    mismatches++;
    final_report();
  end

  initial begin
    modes = '{DOD_MODE_PP, DOD_MODE_PV, DOD_MODE_HM, DOD_MODE_CSP, DOD_MODE_CSV,
              DOD_MODE_CST, 8'h02};
    void'($urandom(43387));
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    ahb(DOD_H_STAT, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(8'h40, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, dc_sup}, 32'h1);
    ahb(DOD_H_CTRL, 1'b1, 32'h1f, dmy);
    ahb(DOD_H_CTRL, 1'b0, 32'h0, rd);
    chk(rd, 32'h1f);
    obj(DOD_IDX_MOD, 8'h00, 1'b0, 32'h0, 1'b0);
    obj(DOD_IDX_MOT, 8'h00, 1'b0, 32'h0, 1'b0);
    obj(DOD_IDX_XMOT, 8'h00, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h000000fe);
    for (int i = 0; i < 12; i++) begin
      s = i == 0 ? 8'h03 : i == 1 ? 8'h1f : i[0] ? 8'($urandom_range(14, 3))
        : 8'($urandom_range(31, 23));
      v = $urandom();
      obj(DOD_IDX_MOD, s, 1'b1, v, 1'b0);
      obj(DOD_IDX_MOD, s, 1'b0, 32'h0, 1'b0);
      chk(rd, v);
    end
    obj(DOD_IDX_MOD, 8'h03, 1'b1, 32'h5a5a0003, 1'b0);
    obj(DOD_IDX_CMD, 8'h00, 1'b0, 32'h0, 1'b1);
    obj(DOD_IDX_CMD, 8'h01, 1'b1, 32'h1, 1'b1);
    obj(DOD_IDX_MOD, 8'h02, 1'b1, 32'hffffffff, 1'b1);
    obj(DOD_IDX_MOD, 8'h0f, 1'b1, 32'hffffffff, 1'b0);
    obj(DOD_IDX_MOD, 8'h20, 1'b1, 32'hffffffff, 1'b1);
    obj(DOD_IDX_MOD, 8'h00, 1'b1, 32'hffffffff, 1'b1);
    obj(DOD_IDX_MOD, 8'h40, 1'b0, 32'h0, 1'b1);
    obj(DOD_IDX_MOT, 8'hff, 1'b0, 32'h0, 1'b1);
    obj(16'h2014, 8'h00, 1'b0, 32'h0, 1'b1);
    obj(DOD_IDX_MOD, 8'h03, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h5a5a0003);
    v = $urandom() | 32'h00000100;
    obj(DOD_IDX_CMD, 8'h00, 1'b1, v, 1'b0);
    obj(DOD_IDX_MOD, 8'h0f, 1'b0, 32'h0, 1'b0);
    chk(rd, v);
    chk(32'(saves), 32'h0);
    obj(DOD_IDX_MOD, 8'h0f, 1'b1, DOD_SAVE_CMD_DEF, 1'b0);
    chk({31'(saves), sv_prof}, {31'h1, 1'b0});
    for (int i = 0; i < 7; i++) begin
      obj(DOD_IDX_MOD, 8'h15, 1'b1, {24'h0, modes[i]}, 1'b0);
      chk({23'h0, mode_ok, op_mode}, {23'h0, 1'(i < 6), modes[i]});
    end
    ahb(DOD_H_CTRL, 1'b1, 32'h1e, dmy);
    obj(DOD_IDX_MOD, 8'h15, 1'b1, 32'h8, 1'b0);
    chk({23'h0, st[DOD_S_REFUSED], op_mode}, {23'h0, 1'b1, 8'h02});
    for (int i = 0; i < 6; i++) begin
      s = i == 0 ? 8'h01 : i == 1 ? 8'hfe : 8'($urandom_range(254, 1));
      v = $urandom();
      obj(i[0] ? DOD_IDX_XMOT : DOD_IDX_MOT, s, 1'b1, v, 1'b0);
      chk({23'h0, last_mot}, {23'h0, i[0] ? 9'(s) + 9'h0ff : 9'(s)});
      obj(i[0] ? DOD_IDX_XMOT : DOD_IDX_MOT, s, 1'b0, 32'h0, 1'b0);
      chk(rd, v);
    end
    ahb(DOD_H_CTRL, 1'b1, 32'h00, dmy);
    obj(DOD_IDX_MOD, 8'h14, 1'b1, 32'h1, 1'b0);
    chk({31'h0, st[DOD_S_REFUSED]}, 32'h1);
    ahb(DOD_H_CTRL, 1'b1, 32'h16, dmy);
    obj(DOD_IDX_MOD, 8'h14, 1'b1, 32'h1, 1'b0);
    chk({31'h0, st[DOD_S_REFUSED]}, 32'h1);
    ahb(DOD_H_CTRL, 1'b1, 32'h0e, dmy);
    obj(DOD_IDX_MOD, 8'h14, 1'b1, 32'h1, 1'b0);
    obj(DOD_IDX_CMD, 8'h00, 1'b1, DOD_SAVE_CMD_DEF, 1'b0);
    chk({30'h0, sv_prof, st[DOD_S_PROFILE]}, {30'h0, 2'b10});
    chk(32'(saves), 32'h2);
    // Flash model: the stored enable comes back at the next power-up
    sys_rst_i <= 1'b1;
    nv_en <= sv_prof;
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    v = 32'(mots);
    obj(DOD_IDX_MOT, 8'h05, 1'b1, 32'h1234, 1'b0);
    chk({30'h0, st[DOD_S_PROFILE], st[DOD_S_REFUSED]}, 32'h3);
    chk(32'(mots), v);
    // Cyclic slot timer under the profile: one tick per programmed period
    ahb(DOD_H_CTRL, 1'b1, 32'h01, dmy);
    obj(DOD_IDX_MOD, 8'h16, 1'b1, 32'h00000007, 1'b0);
    obj(DOD_IDX_MOD, 8'h15, 1'b1, {24'h0, DOD_MODE_CSP}, 1'b0);
    v = 32'(ticks);
    repeat (70) @(posedge clock_i);
    chk(32'(ticks) - v, 32'h0000000a);
    final_report();
  end
endmodule
